/* File: design/tocm_defines.vh */
// Register offsets, field positions, reset values and mode codes for the timer compare block
`ifndef TOCM_DEFINES_VH
`define TOCM_DEFINES_VH

`define TOCM_REG_CTRL 12'h000
`define TOCM_REG_STATUS 12'h004
`define TOCM_REG_COUNT 12'h008
`define TOCM_REG_CMPA 12'h00c
`define TOCM_REG_CMPB 12'h010
`define TOCM_REG_CAPTURE 12'h014
`define TOCM_REG_TEMP 12'h018
`define TOCM_REG_FORCE 12'h01c

`define TOCM_CTRL_MODE_LSB 0
`define TOCM_CTRL_ACTA_LSB 4
`define TOCM_CTRL_ACTB_LSB 6
`define TOCM_CTRL_IEA_BIT 8
`define TOCM_CTRL_IEB_BIT 9
`define TOCM_CTRL_IEOV_BIT 10
`define TOCM_CTRL_IECAP_BIT 11
`define TOCM_CTRL_RESET 32'h0000_0000

`define TOCM_ST_FLAGA_BIT 0
`define TOCM_ST_FLAGB_BIT 1
`define TOCM_ST_OVF_BIT 2
`define TOCM_ST_CAP_BIT 3

`define TOCM_MODE_NORMAL 4'h0
`define TOCM_MODE_CTC_A 4'h4
`define TOCM_MODE_CTC_CAP 4'hc
`define TOCM_MODE_FAST_CAP 4'he
`define TOCM_MODE_FAST_A 4'hf
`define TOCM_MAX 16'hffff
`define TOCM_BOTTOM 16'h0000

`define TOCM_ACT_NONE 2'h0
`define TOCM_ACT_TOGGLE 2'h1
`define TOCM_ACT_CLEAR 2'h2
`define TOCM_ACT_SET 2'h3

`endif

/* File: design/tocm_channel.v */
// One output compare channel: buffered compare value, match detect and output latch
`timescale 1ns/1ns
`include "tocm_defines.vh"

module tocm_channel #(
  parameter WIDTH = 16
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] count,
  input wire tick,
  input wire pwm_mode,
  input wire update_now,
  input wire at_bottom,
  input wire block,
  input wire [1:0] action,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  input wire force_strobe,
  output wire [WIDTH-1:0] rd_value,
  output wire [WIDTH-1:0] active_value,
  output wire match_raw,
  output wire match_event,
  output reg out_latch
);

  reg [WIDTH-1:0] compare_value;
  reg [WIDTH-1:0] buffer_value;
  reg [1:0] eff_action;

  assign match_raw = (count == compare_value);
  assign match_event = tick & match_raw & ~block;
  // In buffered modes software sees the buffer, else the live value
  assign rd_value = pwm_mode ? buffer_value : compare_value;
  assign active_value = compare_value;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value <= {WIDTH{1'b0}};
      buffer_value <= {WIDTH{1'b0}};
    end else begin
      if (wr_en) begin
        buffer_value <= wr_data;
      end
      if (wr_en && !pwm_mode) begin
        compare_value <= wr_data;
      end else if (pwm_mode && update_now) begin
        compare_value <= wr_en ? wr_data : buffer_value;
      end
    end
  end

  // Action bits act directly, no shadow copy
  always @* begin
    eff_action = action;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_latch <= 1'b0;
    end else if (!pwm_mode && (match_event || force_strobe)) begin
      case (eff_action)
        `TOCM_ACT_TOGGLE: out_latch <= ~out_latch;
        `TOCM_ACT_CLEAR: out_latch <= 1'b0;
        `TOCM_ACT_SET: out_latch <= 1'b1;
        default: out_latch <= out_latch;
      endcase
    end else if (pwm_mode && eff_action[1]) begin
      // Mode 2 clears on match and sets at bottom; mode 3 the reverse
      if (match_event) begin
        out_latch <= eff_action[0];
      end else if (tick && at_bottom) begin
        out_latch <= ~eff_action[0];
      end
    end
  end

endmodule

/* File: design/tocm_apb.v */
// APB slave decode with the shared high-byte latch for 16-bit registers
`timescale 1ns/1ns
`include "tocm_defines.vh"

module tocm_apb (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output wire wr_fire,
  output wire rd_fire,
  output wire hit_ctrl,
  output wire hit_status,
  output wire hit_count,
  output wire hit_cmpa,
  output wire hit_cmpb,
  output wire hit_capture,
  output wire hit_temp,
  output wire hit_force,
  output reg [7:0] temp_high,
  output wire [15:0] word16
);

  wire access;
  wire mapped;

  assign access = psel & penable;
  assign hit_ctrl = (paddr == `TOCM_REG_CTRL);
  assign hit_status = (paddr == `TOCM_REG_STATUS);
  assign hit_count = (paddr == `TOCM_REG_COUNT);
  assign hit_cmpa = (paddr == `TOCM_REG_CMPA);
  assign hit_cmpb = (paddr == `TOCM_REG_CMPB);
  assign hit_capture = (paddr == `TOCM_REG_CAPTURE);
  assign hit_temp = (paddr == `TOCM_REG_TEMP);
  assign hit_force = (paddr == `TOCM_REG_FORCE);
  assign mapped = hit_ctrl | hit_status | hit_count | hit_cmpa | hit_cmpb | hit_capture
    | hit_temp | hit_force;
  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign wr_fire = access & pwrite & mapped;
  assign rd_fire = access & ~pwrite & mapped;
  // Low-byte write merges the latched high byte in the same cycle
  assign word16 = {temp_high, pwdata[7:0]};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_high <= 8'h00;
    end else if (wr_fire && hit_temp) begin
      temp_high <= pwdata[7:0];
    end
  end

endmodule

/* File: design/tocm_top.v */
// Timer/counter output compare block with APB registers
`timescale 1ns/1ns
`include "tocm_defines.vh"

module tocm_top #(
  parameter WIDTH = 16
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire timer_tick,
  input wire capture_event,
  input wire [1:0] irq_ack,
  input wire overflow_ack,
  input wire capture_ack,
  input wire [1:0] port_value,
  input wire [1:0] compare_pin_direction,
  output wire [1:0] pin_out,
  output wire [1:0] pin_oe,
  output wire [1:0] compare_irq,
  output wire overflow_irq,
  output wire capture_irq,
  output wire [1:0] compare_output
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave

  wire wr_fire;
  wire rd_fire;
  wire hit_ctrl;
  wire hit_status;
  wire hit_count;
  wire hit_cmpa;
  wire hit_cmpb;
  wire hit_capture;
  wire hit_temp;
  wire hit_force;
  wire [7:0] temp_high;
  wire [15:0] word16;

  tocm_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .wr_fire(wr_fire),
    .rd_fire(rd_fire),
    .hit_ctrl(hit_ctrl),
    .hit_status(hit_status),
    .hit_count(hit_count),
    .hit_cmpa(hit_cmpa),
    .hit_cmpb(hit_cmpb),
    .hit_capture(hit_capture),
    .hit_temp(hit_temp),
    .hit_force(hit_force),
    .temp_high(temp_high),
    .word16(word16)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control register

  reg [11:0] ctrl;
  wire [3:0] waveform_mode_sel;
  wire [1:0] compare_output_action [0:1];
  wire [1:0] compare_irq_enable;
  wire overflow_irq_enable;
  wire capture_irq_enable;

  assign waveform_mode_sel = ctrl[`TOCM_CTRL_MODE_LSB +: 4];
  assign compare_output_action[0] = ctrl[`TOCM_CTRL_ACTA_LSB +: 2];
  assign compare_output_action[1] = ctrl[`TOCM_CTRL_ACTB_LSB +: 2];
  assign compare_irq_enable = {ctrl[`TOCM_CTRL_IEB_BIT], ctrl[`TOCM_CTRL_IEA_BIT]};
  assign overflow_irq_enable = ctrl[`TOCM_CTRL_IEOV_BIT];
  assign capture_irq_enable = ctrl[`TOCM_CTRL_IECAP_BIT];

  // Mode change touches neither counter nor output latches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 12'h000;
    end else if (wr_fire && hit_ctrl) begin
      ctrl <= pwdata[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode; only the mode bits steer counting

  wire pwm_mode;
  wire top_from_a;
  wire top_from_cap;
  wire fixed_top;
  reg [15:0] top_value;
  wire [15:0] cap_value;
  wire [15:0] active_a;

  // Twelve PWM modes: every code except 0, 4, 12 and 13
  assign pwm_mode = (waveform_mode_sel != `TOCM_MODE_NORMAL)
    && (waveform_mode_sel != `TOCM_MODE_CTC_A)
    && (waveform_mode_sel != `TOCM_MODE_CTC_CAP)
    && (waveform_mode_sel != 4'hd);
  assign top_from_a = (waveform_mode_sel == `TOCM_MODE_CTC_A)
    || (waveform_mode_sel == `TOCM_MODE_FAST_A);
  assign top_from_cap = (waveform_mode_sel == `TOCM_MODE_CTC_CAP)
    || (waveform_mode_sel == `TOCM_MODE_FAST_CAP);
  assign fixed_top = ~top_from_a & ~top_from_cap & pwm_mode;

  // Only single-slope counting is built; dual-slope codes count up the same way
  always @* begin
    case (waveform_mode_sel[1:0])
      2'h1: top_value = 16'h00ff;
      2'h2: top_value = 16'h01ff;
      2'h3: top_value = 16'h03ff;
      default: top_value = `TOCM_MAX;
    endcase
    if (top_from_a) begin
      top_value = active_a;
    end else if (top_from_cap) begin
      top_value = cap_value;
    end else if (!fixed_top) begin
      top_value = `TOCM_MAX;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter

  reg [15:0] timer_count;
  reg block_pending;
  wire count_write;
  wire at_top;
  wire at_bottom;
  wire top_hit;
  wire [15:0] next_count;

  assign count_write = wr_fire & hit_count;
  assign at_top = (timer_count == top_value);
  assign at_bottom = (timer_count == `TOCM_BOTTOM);
  // A blocked top match lets the counter run on to the maximum
  assign top_hit = at_top & ~block_pending & (top_value != `TOCM_MAX);
  // At the maximum the plain carry does the wrap, so no clear is needed
  assign next_count = top_hit ? `TOCM_BOTTOM : timer_count + 16'h0001;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count <= 16'h0000;
    end else if (count_write) begin
      timer_count <= word16;
    end else if (timer_tick) begin
      timer_count <= next_count;
    end
  end

  // Block stays armed until a timer tick consumes it, even while stopped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_pending <= 1'b0;
    end else if (count_write) begin
      block_pending <= 1'b1;
    end else if (timer_tick) begin
      block_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare channels

  wire [15:0] rd_value [0:1];
  wire [15:0] active_value [0:1];
  wire [1:0] match_event;
  wire [1:0] match_raw;
  wire [1:0] cmp_hit;
  wire [1:0] force_fire;
  wire update_now;
  wire wrap_now;

  assign cmp_hit = {hit_cmpb, hit_cmpa};
  assign active_a = active_value[0];
  // The counter really returns to bottom; a write in the same cycle wins
  assign wrap_now = ~count_write & (top_hit | (at_top & (top_value == `TOCM_MAX)));
  // Single-slope modes reload at the top wrap
  assign update_now = timer_tick & wrap_now;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
      // Strobe bits store nothing
      assign force_fire[gi] = wr_fire & hit_force & pwdata[gi] & ~pwm_mode;
      tocm_channel #(
        .WIDTH(WIDTH)
      ) u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .count(timer_count),
        .tick(timer_tick),
        .pwm_mode(pwm_mode),
        .update_now(update_now),
        .at_bottom(wrap_now),
        .block(block_pending),
        .action(compare_output_action[gi]),
        .wr_en(wr_fire & cmp_hit[gi]),
        .wr_data(word16),
        .force_strobe(force_fire[gi]),
        .rd_value(rd_value[gi]),
        .active_value(active_value[gi]),
        .match_raw(match_raw[gi]),
        .match_event(match_event[gi]),
        .out_latch(compare_output[gi])
      );
      // Action nonzero hands the pin to the compare output
      assign pin_out[gi] = (compare_output_action[gi] != `TOCM_ACT_NONE)
        ? compare_output[gi] : port_value[gi];
      assign pin_oe[gi] = compare_pin_direction[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Capture register

  reg [15:0] capture_value;
  reg capture_sync1;
  reg capture_sync2;
  reg capture_prev;
  wire capture_rise;
  wire capture_hit;

  assign cap_value = capture_value;
  assign capture_rise = capture_sync2 & ~capture_prev;
  // Edge detector is off while the capture value sets the top
  assign capture_hit = capture_rise & ~top_from_cap;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_sync1 <= 1'b0;
      capture_sync2 <= 1'b0;
      capture_prev <= 1'b0;
      capture_value <= 16'h0000;
    end else begin
      capture_sync1 <= capture_event;
      capture_sync2 <= capture_sync1;
      capture_prev <= capture_sync2;
      if (top_from_cap && wr_fire && hit_capture) begin
        capture_value <= word16;
      end else if (capture_rise && !top_from_cap) begin
        capture_value <= timer_count;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags; a setting event wins over a clear in the same cycle

  reg [3:0] flags;
  wire [3:0] flag_set;
  wire [3:0] flag_clr;
  wire ovf_set;

  // Normal and CTC counting flag the carry from the maximum to zero
  // PWM modes flag the wrap at top instead
  assign ovf_set = timer_tick & ~count_write
    & (pwm_mode ? wrap_now : (timer_count == `TOCM_MAX));
  // Compare and overflow flags set on the tick following detection; the capture flag sets on the next clock after the edge, tick or not
  assign flag_set = {capture_hit, ovf_set, match_event};
  assign flag_clr = ({4{wr_fire & hit_status}} & pwdata[3:0])
    | {capture_ack, overflow_ack, irq_ack};

  // A clear in the cycle of a new event loses, so no event is dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 4'h0;
    end else begin
      flags <= flag_set | (flags & ~flag_clr);
    end
  end

  assign compare_irq = flags[1:0] & compare_irq_enable;
  assign overflow_irq = flags[`TOCM_ST_OVF_BIT] & overflow_irq_enable;
  assign capture_irq = flags[`TOCM_ST_CAP_BIT] & capture_irq_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data; compare reads bypass the high-byte latch
  // Force strobes read back as zero since they store nothing

  always @* begin
    prdata = 32'h0000_0000;
    if (rd_fire) begin
      if (hit_ctrl) begin
        prdata = {20'h00000, ctrl};
      end else if (hit_status) begin
        prdata = {28'h0000000, flags};
      end else if (hit_count) begin
        prdata = {16'h0000, timer_count};
      end else if (hit_cmpa) begin
        prdata = {16'h0000, rd_value[0]};
      end else if (hit_cmpb) begin
        prdata = {16'h0000, rd_value[1]};
      end else if (hit_capture) begin
        prdata = {16'h0000, capture_value};
      end else if (hit_temp) begin
        prdata = {24'h000000, temp_high};
      end
    end
  end

endmodule

/* File: tb/tocm_tick_src.sv */
// Prescaler stand-in that issues counted bursts of timer ticks
`timescale 1ns/1ns
module tocm_tick_src (
  input logic pclk,
  input logic presetn,
  input logic req,
  input logic [7:0] req_n,
  input logic [1:0] gap,
  output logic busy,
  output logic timer_tick
);
  logic [7:0] left;
  logic [1:0] ph;
  assign busy = (left != 8'h0) || timer_tick;
  // No ticks between bursts, as with a stopped timer clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 8'h0;
      ph <= 2'h0;
      timer_tick <= 1'b0;
    end else if (req) begin
      left <= req_n;
      ph <= 2'h0;
      timer_tick <= 1'b0;
    end else if (left != 8'h0 && ph == gap) begin
      left <= left - 8'h1;
      ph <= 2'h0;
      timer_tick <= 1'b1;
    end else begin
      ph <= ph + 2'h1;
      timer_tick <= 1'b0;
    end
  end
endmodule

/* File: tb/tocm_checker.sv */
// Port-level assertions for the timer compare block
`timescale 1ns/1ns
module tocm_checker (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic timer_tick,
  input logic [1:0] irq_ack,
  input logic overflow_ack,
  input logic [1:0] port_value,
  input logic [1:0] compare_pin_direction,
  input logic [1:0] pin_out,
  input logic [1:0] pin_oe,
  input logic [1:0] compare_irq,
  input logic overflow_irq,
  input logic [1:0] compare_output
);
  logic [3:0] act;
  logic [3:0] mode;
  logic [1:0] exp_pin;
  logic fwr;
  logic act_a_off;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Shadow of the control fields, since the checker cannot see inside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act <= 4'h0;
      mode <= 4'h0;
    end else if (psel && penable && pwrite && paddr == 12'h000) begin
      act <= pwdata[7:4];
      mode <= pwdata[3:0];
    end
  end
  assign fwr = psel && penable && pwrite && paddr == 12'h01c;
  assign act_a_off = act[1:0] == 2'h0;
  assign exp_pin[0] = (act[1:0] != 2'h0) ? compare_output[0] : port_value[0];
  assign exp_pin[1] = (act[3:2] != 2'h0) ? compare_output[1] : port_value[1];
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_force_idle;
    fwr && !timer_tick;
  endsequence
  a_ready_high: assert property (s_access |-> pready) else $error("pready low");
  a_oe_follow: assert property (pin_oe == compare_pin_direction)
    else $error("pin enable mismatch");
  a_pin_mux: assert property (pin_out == exp_pin) else $error("pin mux wrong");
  a_out_cause: assert property ($changed(compare_output) |-> $past(timer_tick) || $past(fwr))
    else $error("output changed without cause");
  a_out_noact: assert property ($past(act_a_off) |-> $stable(compare_output[0]))
    else $error("output moved with action off");
  a_force_toggle: assert property (s_force_idle ##0 (pwdata[0] && act[1:0] == 2'h1
    && mode == 4'h0) |=> compare_output[0] != $past(compare_output[0]))
    else $error("force did not toggle");
  a_force_noflag: assert property (s_force_idle |=> !$rose(compare_irq[0]))
    else $error("force raised flag");
  a_ack_clear: assert property (irq_ack[0] && !timer_tick |=> !compare_irq[0])
    else $error("ack left irq");
  a_ovf_ack: assert property (overflow_ack && !timer_tick |=> !overflow_irq)
    else $error("ack left overflow irq");
  a_force_read: assert property (s_access ##0 (!pwrite && paddr == 12'h01c)
    |-> prdata == 32'h0) else $error("force reads nonzero");
  a_unmapped_err: assert property (s_access ##0 (paddr > 12'h01c)
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
endmodule

bind tocm_top tocm_checker u_tocm_checker (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_tick, .irq_ack, .overflow_ack,
  .port_value, .compare_pin_direction, .pin_out, .pin_oe, .compare_irq, .overflow_irq,
  .compare_output);

/* File: tb/tb_top.sv */
// Self-checking bench for the timer compare block
`timescale 1ns/1ns
`include "tocm_defines.vh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic capture_event = 1'b0;
  logic [1:0] irq_ack = 2'h0;
  logic overflow_ack = 1'b0;
  logic capture_ack = 1'b0;
  logic [1:0] port_value = 2'h0;
  logic [1:0] compare_pin_direction = 2'h0;
  logic req = 1'b0;
  logic [7:0] req_n = 8'h0;
  logic [1:0] gap = 2'h0;
  wire [31:0] prdata;
  wire pready, pslverr, timer_tick, busy, overflow_irq, capture_irq;
  wire [1:0] pin_out, pin_oe, compare_irq, compare_output;
  integer err_total = 0;
  integer tests_run = 0;
  integer seed = 32'h94af9e11;
  integer i;
  logic [31:0] rd;
  logic serr;
  logic [15:0] v;
  logic [3:0] act;
  logic [1:0] exp_out;
  logic [1:0] hold;
  always #50 pclk = ~pclk;
  tocm_top u_tocm_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timer_tick, .capture_event, .irq_ack, .overflow_ack,
    .capture_ack, .port_value, .compare_pin_direction, .pin_out, .pin_oe,
    .compare_irq, .overflow_irq, .capture_irq, .compare_output);
  tocm_tick_src u_tocm_tick_src (.pclk, .presetn, .req, .req_n, .gap, .busy, .timer_tick);
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task timed_out;
    err_total++;
    $display("[ERR] %0t wait timed out", $time);
    final_report;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) timed_out;
  endtask
  // Sixteen-bit stores go through the shared high-byte latch
  task automatic wr16(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, `TOCM_REG_TEMP, {24'h0, d[15:8]});
    apb(1'b1, a, {24'h0, d[7:0]});
  endtask
  task automatic ticks(input logic [7:0] n);
    integer k;
    @(posedge pclk);
    req <= 1'b1;
    req_n <= n;
    gap <= 2'($random(seed));
    @(posedge pclk);
    req <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge pclk);
      if (busy !== 1'b1) break;
    end
    if (k == 200) timed_out;
  endtask
  task automatic pulse_wait;
    @(posedge pclk);
    irq_ack <= 2'h0;
    overflow_ack <= 1'b0;
    capture_ack <= 1'b0;
    @(negedge pclk);
  endtask
  function automatic logic nxt(input logic [1:0] a, input logic cur);
    case (a)
      `TOCM_ACT_NONE: nxt = cur;
      `TOCM_ACT_TOGGLE: nxt = ~cur;
      `TOCM_ACT_CLEAR: nxt = 1'b0;
      default: nxt = 1'b1;
    endcase
  endfunction
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check(compare_output, 0);
    apb(1'b0, `TOCM_REG_CTRL, 0);
    check(rd, `TOCM_CTRL_RESET);
    apb(1'b0, `TOCM_REG_FORCE, 0);
    check(rd, 0);
    apb(1'b0, 12'h020, 0);
    check({serr, rd}, {1'b1, 32'h0});
    for (i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      wr16(i[0] ? `TOCM_REG_CMPB : `TOCM_REG_CMPA, v);
      apb(1'b0, i[0] ? `TOCM_REG_CMPB : `TOCM_REG_CMPA, 0);
      check(rd[15:0], v);
    end
    apb(1'b1, `TOCM_REG_TEMP, 32'ha5);
    apb(1'b1, `TOCM_REG_CMPA, 32'h01);
    apb(1'b1, `TOCM_REG_CMPB, 32'h02);
    apb(1'b0, `TOCM_REG_CMPB, 0);
    check(rd[15:0], 16'ha502);
    exp_out = 2'h0;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      act = {2'($random(seed)), i[1:0]};
      port_value <= 2'($random(seed));
      compare_pin_direction <= 2'($random(seed));
      apb(1'b1, `TOCM_REG_CTRL, {24'h0, act, `TOCM_MODE_NORMAL});
      apb(1'b1, `TOCM_REG_FORCE, 32'h3);
      @(negedge pclk);
      exp_out = {nxt(act[3:2], exp_out[1]), nxt(act[1:0], exp_out[0])};
      check(compare_output, exp_out);
      check(pin_out[0], act[1:0] != 0 ? exp_out[0] : port_value[0]);
      check(pin_out[1], act[3:2] != 0 ? exp_out[1] : port_value[1]);
      check(pin_oe, compare_pin_direction);
      apb(1'b0, `TOCM_REG_STATUS, 0);
      check(rd[1:0], 0);
    end
    hold = compare_output;
    apb(1'b1, `TOCM_REG_CTRL, {28'h0, `TOCM_MODE_FAST_A});
    apb(1'b1, `TOCM_REG_CTRL, 32'h500);
    @(negedge pclk);
    check(compare_output, hold);
    wr16(`TOCM_REG_CMPA, 16'h0103);
    wr16(`TOCM_REG_COUNT, 16'h0100);
    ticks(3);
    apb(1'b0, `TOCM_REG_STATUS, 0);
    check(rd[0], 0);
    ticks(1);
    apb(1'b0, `TOCM_REG_STATUS, 0);
    check(rd[0], 1);
    check(compare_irq[0], 1);
    check(compare_output, hold);
    apb(1'b0, `TOCM_REG_COUNT, 0);
    check(rd[15:0], 16'h0104);
    irq_ack <= 2'h1;
    pulse_wait;
    check(compare_irq[0], 0);
    wr16(`TOCM_REG_COUNT, 16'h0103);
    ticks(1);
    apb(1'b0, `TOCM_REG_STATUS, 0);
    check(rd[0], 0);
    wr16(`TOCM_REG_COUNT, 16'h0102);
    ticks(2);
    apb(1'b0, `TOCM_REG_STATUS, 0);
    check(rd[0], 1);
    apb(1'b1, `TOCM_REG_STATUS, 32'h1);
    apb(1'b0, `TOCM_REG_STATUS, 0);
    check(rd[0], 0);
    wr16(`TOCM_REG_COUNT, 16'hffff);
    ticks(1);
    apb(1'b0, `TOCM_REG_COUNT, 0);
    check(rd[15:0], 16'h0000);
    apb(1'b0, `TOCM_REG_STATUS, 0);
    check({rd[2], overflow_irq}, 2'h3);
    overflow_ack <= 1'b1;
    pulse_wait;
    check(overflow_irq, 0);
    for (i = 0; i < 2; i++) begin
      wr16(`TOCM_REG_COUNT, i[0] ? 16'h2222 : 16'h1111);
      capture_event <= 1'b1;
      repeat (6) @(posedge pclk);
      capture_event <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    apb(1'b0, `TOCM_REG_CAPTURE, 0);
    check(rd[15:0], 16'h2222);
    apb(1'b0, `TOCM_REG_STATUS, 0);
    check(rd[3], 1);
    apb(1'b1, `TOCM_REG_STATUS, 32'h8);
    apb(1'b0, `TOCM_REG_STATUS, 0);
    check(rd[3], 0);
    apb(1'b1, `TOCM_REG_CTRL, 32'h800);
    capture_event <= 1'b1;
    repeat (5) @(posedge pclk);
    check(capture_irq, 1);
    capture_ack <= 1'b1;
    pulse_wait;
    check(capture_irq, 0);
    // Fast PWM with top from channel A; channel B sets at the wrap
    hold = compare_output;
    apb(1'b1, `TOCM_REG_CTRL, 32'h08f);
    wr16(`TOCM_REG_COUNT, 16'h0100);
    wr16(`TOCM_REG_CMPA, 16'h0105);
    apb(1'b0, `TOCM_REG_CMPA, 0);
    check(rd[15:0], 16'h0105);
    ticks(4);
    apb(1'b0, `TOCM_REG_COUNT, 0);
    check(rd[15:0], 16'h0000);
    check(compare_output, {1'b1, hold[0]});
    wr16(`TOCM_REG_COUNT, 16'h0105);
    ticks(1);
    apb(1'b0, `TOCM_REG_COUNT, 0);
    check(rd[15:0], 16'h0106);
    final_report;
  end
endmodule
